// ---- hw/opfs_pkg.sv ----
/*
  Package for the output pin function select block: register offsets,
  field positions, reset values and the function and drive encodings.
  Assumes a byte-wide register port addressed by the in-page offset.
*/
package opfs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OPFS_ADDR_PIN1_CFG  = 8'h22;
  localparam logic [7:0] OPFS_ADDR_PIN2_CFG  = 8'h23;
  localparam logic [7:0] OPFS_ADDR_PIN3_CFG  = 8'h24;
  localparam logic [7:0] OPFS_ADDR_PIN4_CFG  = 8'h25;
  localparam logic [7:0] OPFS_ADDR_LEVELS    = 8'h29;
  localparam logic [7:0] OPFS_PAGE_ID        = 8'h00;
  localparam logic [7:0] OPFS_CFG_RESET      = 8'h00;
  localparam logic [7:0] OPFS_LEVELS_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int OPFS_FUNC_MSB   = 7;
  localparam int OPFS_FUNC_LSB   = 4;
  localparam int OPFS_DRIVE_MSB  = 2;
  localparam int OPFS_DRIVE_LSB  = 0;
  localparam int OPFS_LEVEL_PIN1 = 6;
  localparam int OPFS_LEVEL_PIN4 = 3;
  localparam logic [7:0] OPFS_CFG_RMASK    = 8'hf7;
  localparam logic [7:0] OPFS_LEVELS_RMASK = 8'h78;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] OPFS_FN_DISABLED = 4'h0;
  localparam logic [3:0] OPFS_FN_GP_OUT    = 4'h1;
  localparam logic [3:0] OPFS_FN_IRQ       = 4'h2;
  localparam logic [3:0] OPFS_FN_SDOUT     = 4'h3;
  localparam logic [3:0] OPFS_FN_PDM_CLOCK = 4'h4;

  localparam logic [2:0] OPFS_DRV_HIZ        = 3'h0;
  localparam logic [2:0] OPFS_DRV_ALO_AHI    = 3'h1;
  localparam logic [2:0] OPFS_DRV_ALO_WHI    = 3'h2;
  localparam logic [2:0] OPFS_DRV_ALO_ZHI    = 3'h3;
  localparam logic [2:0] OPFS_DRV_WLO_AHI    = 3'h4;
  localparam logic [2:0] OPFS_DRV_ZLO_AHI    = 3'h5;

endpackage

// ---- hw/opfs_pin_if.sv ----
/*
  Interface carrying one pin's settings from the register file to the
  pin driver. Assumes both ends share the block clock.
*/
`timescale 1ns/100ps
interface opfs_pin_if;
  logic [3:0] func;
  logic [2:0] drive;
  logic       level;
  modport regs (output func, drive, level);
  modport drv  (input  func, drive, level);
endinterface

// ---- hw/opfs_pin_drv.sv ----
/*
  One output pin driver: picks the source from the function code and
  turns it into drive controls for the pad.
  Assumes routed sources come from logic on the same clock.
*/
`timescale 1ns/100ps
module opfs_pin_drv (
  input  wire logic  mclk_in,
  input  wire logic  rst_in,
  opfs_pin_if.drv    cfg,
  input  wire logic  irq_src_in,
  input  wire logic  sdout_src_in,
  input  wire logic  pdm_clock_src_in,
  input  wire logic  sdout_oe_n_in,
  output logic       pin_o_out,
  output logic       pin_oe_n_out,
  output logic       pin_weak_out
);

  logic src;
  logic drv_d;
  logic oe_n_d;
  logic weak_d;

  always_comb begin
    unique case (cfg.func)
      opfs_pkg::OPFS_FN_GP_OUT:    src = cfg.level;
      opfs_pkg::OPFS_FN_IRQ:       src = irq_src_in;
      opfs_pkg::OPFS_FN_SDOUT:     src = sdout_src_in;
      opfs_pkg::OPFS_FN_PDM_CLOCK: src = pdm_clock_src_in;
      default:                     src = 1'b0;
    endcase
  end

  // --------------------------------------------------------------
  // Drive decode
  // --------------------------------------------------------------
  always_comb begin
    drv_d  = src;
    oe_n_d = 1'b1;
    weak_d = 1'b0;
    if (cfg.func == opfs_pkg::OPFS_FN_SDOUT) begin
      // Serial port owns its own tristate; drive field ignored
      oe_n_d = sdout_oe_n_in;
    end else if (cfg.func == opfs_pkg::OPFS_FN_GP_OUT ||
                 cfg.func == opfs_pkg::OPFS_FN_IRQ ||
                 cfg.func == opfs_pkg::OPFS_FN_PDM_CLOCK) begin
      unique case (cfg.drive)
        opfs_pkg::OPFS_DRV_ALO_AHI: oe_n_d = 1'b0;
        opfs_pkg::OPFS_DRV_ALO_WHI: begin
          oe_n_d = 1'b0;
          weak_d = src;
        end
        opfs_pkg::OPFS_DRV_ALO_ZHI: oe_n_d = src;
        opfs_pkg::OPFS_DRV_WLO_AHI: begin
          oe_n_d = 1'b0;
          weak_d = ~src;
        end
        opfs_pkg::OPFS_DRV_ZLO_AHI: oe_n_d = ~src;
        // Hi-Z and the reserved codes leave the pad floating
        default:                    oe_n_d = 1'b1;
      endcase
    end
    // Disabled and reserved functions never drive
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pin_o_out    <= 1'b0;
      pin_oe_n_out <= 1'b1;
      pin_weak_out <= 1'b0;
    end else begin
      pin_o_out    <= drv_d;
      pin_oe_n_out <= oe_n_d;
      pin_weak_out <= weak_d;
    end
  end

endmodule

// ---- hw/opfs_top.sv ----
/*
  Output pin function select: four pin configuration registers, the
  output level register and four pin drivers.
  Assumes a byte register port on the block clock and routed sources
  (interrupt, secondary serial data, PDM clock) from the same clock.
*/
`timescale 1ns/100ps
module opfs_top (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       irq_src_in,
  input  wire logic       sdout_src_in,
  input  wire logic       sdout_oe_n_in,
  input  wire logic       pdm_clock_src_in,
  output logic      [3:0] pin_o_out,
  output logic      [3:0] pin_oe_n_out,
  output logic      [3:0] pin_weak_out
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] cfg_q [4];
  logic [7:0] levels_q;
  logic [7:0] rdata_d;
  logic [2:0] cfg_sel;

  function automatic logic [2:0] cfg_index(input logic [7:0] a);
    if (a == opfs_pkg::OPFS_ADDR_PIN1_CFG) cfg_index = 3'h0;
    else if (a == opfs_pkg::OPFS_ADDR_PIN2_CFG) cfg_index = 3'h1;
    else if (a == opfs_pkg::OPFS_ADDR_PIN3_CFG) cfg_index = 3'h2;
    else if (a == opfs_pkg::OPFS_ADDR_PIN4_CFG) cfg_index = 3'h3;
    else cfg_index = 3'h4;
  endfunction

  // Code 4 marks an address outside the pin registers
  assign cfg_sel = cfg_index(addr_in);

  // Reserved codes are stored as written; the drivers treat them as
  // floating, except that the serial data function ignores the drive field
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      for (int i = 0; i < 4; i++) begin
        cfg_q[i] <= opfs_pkg::OPFS_CFG_RESET;
      end
    end else if (wr_in && cfg_sel != 3'h4) begin
      // Bit 3 never stores
      cfg_q[cfg_sel[1:0]] <= wdata_in & opfs_pkg::OPFS_CFG_RMASK;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      levels_q <= opfs_pkg::OPFS_LEVELS_RESET;
    end else if (wr_in && addr_in == opfs_pkg::OPFS_ADDR_LEVELS) begin
      levels_q <= wdata_in & opfs_pkg::OPFS_LEVELS_RMASK;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (cfg_sel != 3'h4) begin
      rdata_d = cfg_q[cfg_sel[1:0]];
    end else if (addr_in == opfs_pkg::OPFS_ADDR_LEVELS) begin
      rdata_d = levels_q;
    end
  end

  // Read data holds only in the cycle after the strobe; unmapped is zero
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= rdata_d;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 4; p++) begin : g_pin
    opfs_pin_if pin_cfg ();
    assign pin_cfg.func  = cfg_q[p][opfs_pkg::OPFS_FUNC_MSB:
                                    opfs_pkg::OPFS_FUNC_LSB];
    assign pin_cfg.drive = cfg_q[p][opfs_pkg::OPFS_DRIVE_MSB:
                                    opfs_pkg::OPFS_DRIVE_LSB];
    assign pin_cfg.level = levels_q[opfs_pkg::OPFS_LEVEL_PIN1 - p];

    opfs_pin_drv u_drv (
      .mclk_in          (mclk_in),
      .rst_in           (rst_in),
      .cfg              (pin_cfg),
      .irq_src_in       (irq_src_in),
      .sdout_src_in     (sdout_src_in),
      .pdm_clock_src_in (pdm_clock_src_in),
      .sdout_oe_n_in    (sdout_oe_n_in),
      .pin_o_out        (pin_o_out[p]),
      .pin_oe_n_out     (pin_oe_n_out[p]),
      .pin_weak_out     (pin_weak_out[p])
    );
  end

endmodule

// ---- test/opfs_props.sv ----
/* Checker for opfs_top, bound to its ports.
   Assumes one clock, mclk_in, and synchronous reset rst_in. */
`timescale 1ns/100ps
module opfs_props (
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       irq_src_in,
  input wire logic       sdout_src_in,
  input wire logic       sdout_oe_n_in,
  input wire logic       pdm_clock_src_in,
  input wire logic [3:0] pin_o_out,
  input wire logic [3:0] pin_oe_n_out,
  input wire logic [3:0] pin_weak_out
);
  // Shadow copies, so pin checks need not reach into the design
  logic [7:0] cfg_q [4];
  logic [7:0] lvl_q;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cfg_q <= '{default: 8'h00};
      lvl_q <= 8'h00;
    end else if (wr_in) begin
      if (addr_in >= 8'h22 && addr_in <= 8'h25) begin
        cfg_q[2'(addr_in - 8'h22)] <= wdata_in;
      end
      if (addr_in == 8'h29) begin
        lvl_q <= wdata_in;
      end
    end
  end
  function automatic logic oen(input logic [7:0] c, input logic s);
    case (c[2:0])
      3'h1, 3'h2, 3'h4: return 1'b0;
      3'h3: return s;
      3'h5: return !s;
      default: return 1'b1;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Bit 3 of the level register is a live level bit, so pin registers only
  property p_rsv; rd_in && addr_in >= 8'h22 && addr_in <= 8'h25 |=>
    !rdata_out[3]; endproperty
  a_rsv: assert property (p_rsv) else $error("bit 3 read nonzero");
  property p_lvl; rd_in && addr_in == 8'h29 |=> !(|(rdata_out & 8'h87));
  endproperty
  a_lvl: assert property (p_lvl) else $error("level spare bits");
  property p_rst; $fell(rst_in) |-> pin_oe_n_out == 4'hf; endproperty
  a_rst: assert property (p_rst) else $error("pins drive at reset");
  property p_drv; cfg_q[0][7:4] == 4'h1 |=>
    pin_oe_n_out[0] == oen($past(cfg_q[0]), $past(lvl_q[6])); endproperty
  a_drv: assert property (p_drv) else $error("drive decode");
  property p_gpo; cfg_q[0] == 8'h11 |=> pin_o_out[0] == $past(lvl_q[6]);
  endproperty
  a_gpo: assert property (p_gpo) else $error("pin1 level");
  property p_irq; cfg_q[1] == 8'h21 |=> pin_o_out[1] == $past(irq_src_in);
  endproperty
  a_irq: assert property (p_irq) else $error("pin2 irq");
  property p_sd; cfg_q[2][7:4] == 4'h3 |=>
    pin_oe_n_out[2] == $past(sdout_oe_n_in); endproperty
  a_sd: assert property (p_sd) else $error("pin3 serial enable");
  property p_hiz4; cfg_q[3][2:0] == 3'h0 && cfg_q[3][7:4] != 4'h3 |=>
    pin_oe_n_out[3]; endproperty
  a_hiz4: assert property (p_hiz4) else $error("pin4 not hi-z");
  property p_dis; cfg_q[1][7:4] == 4'h0 |=> pin_oe_n_out[1]; endproperty
  a_dis: assert property (p_dis) else $error("pin2 drives");
endmodule
bind opfs_top opfs_props u_props (.mclk_in(mclk_in), .rst_in(rst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .irq_src_in(irq_src_in),
  .sdout_src_in(sdout_src_in), .sdout_oe_n_in(sdout_oe_n_in),
  .pdm_clock_src_in(pdm_clock_src_in), .pin_o_out(pin_o_out),
  .pin_oe_n_out(pin_oe_n_out), .pin_weak_out(pin_weak_out));

// ---- test/tb_opfs_top.sv ----
/* Self-checking bench for opfs_top: registers, drive modes, routing.
   Assumes the design files are compiled first. */
`timescale 1ns/100ps
module tb_opfs_top;
  logic       mclk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic [3:0] src = 4'h0;
  logic [7:0] rdata_out;
  logic [3:0] pin_o_out;
  logic [3:0] pin_oe_n_out;
  logic [3:0] pin_weak_out;
  int         fail_count = 0;
  int         total_checks = 0;
  always #50 mclk_in = ~mclk_in;
  opfs_top DUT (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .irq_src_in(src[0]), .sdout_src_in(src[1]),
    .sdout_oe_n_in(src[3]), .pdm_clock_src_in(src[2]),
    .pin_o_out(pin_o_out), .pin_oe_n_out(pin_oe_n_out),
    .pin_weak_out(pin_weak_out));
  task automatic chk(input string n, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(negedge mclk_in);
    chk("rdata", e, rdata_out);
  endtask
  // Pins lag the registers by one cycle
  task automatic settle;
    @(posedge mclk_in);
    @(negedge mclk_in);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    chk("oe_n", 8'h0f, pin_oe_n_out);
    for (int a = 8'h22; a < 8'h2a; a++) rd(8'(a), 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(8'h22 + 8'(p), 8'h4d);
      rd(8'h22 + 8'(p), 8'h45);
    end
    wr(8'h29, 8'hff);
    rd(8'h29, 8'h78);
    @(negedge mclk_in);
    chk("rdata_idle", 8'h00, rdata_out);
    wr(8'h26, 8'h5a);
    rd(8'h26, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_drive;
    logic [5:0] oen0 = 6'h21, oen1 = 6'h09, wk0 = 6'h10, wk1 = 6'h04;
    for (int p = 1; p < 4; p++) wr(8'h22 + 8'(p), 8'h05);
    for (int s = 0; s < 2; s++) begin
      wr(8'h29, s ? 8'h40 : 8'h00);
      for (int d = 0; d < 6; d++) begin
        wr(8'h22, 8'h10 | 8'(d));
        settle();
        chk("oe_n1", s ? oen1[d] : oen0[d], pin_oe_n_out[0]);
        chk("weak1", s ? wk1[d] : wk0[d], pin_weak_out[0]);
        if (d == 1) chk("o1", 8'(s), pin_o_out[0]);
      end
    end
    chk("oe_n234", 8'h07, pin_oe_n_out[3:1]);
    $display("t_drive done");
  endtask
  task automatic t_route;
    wr(8'h23, 8'h21);
    wr(8'h24, 8'h30);
    wr(8'h25, 8'h41);
    for (int k = 0; k < 16; k++) begin
      @(posedge mclk_in);
      src <= 4'(k);
      settle();
      chk("o234", src[2:0], pin_o_out[3:1]);
      chk("oe234", {src[3], 1'b0}, pin_oe_n_out[3:1]);
    end
    wr(8'h25, 8'h40);
    settle();
    chk("oe_n4", 8'h01, pin_oe_n_out[3]);
    for (int p = 0; p < 4; p++) wr(8'h22 + 8'(p), 8'h11);
    wr(8'h29, 8'h50);
    settle();
    chk("o_all", 8'h05, pin_o_out);
    $display("t_route done");
  endtask
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_regs();
    t_drive();
    t_route();
    finish_test();
  end
  // Tests need about 150 cycles; allow well over double
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
endmodule
